// ---- src/fsrc_defs.svh ----
// offsets, field positions, reset values and timing counts of the pause controller
`ifndef FSRC_DEFS_SVH
`define FSRC_DEFS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define FSRC_OFF_STATUS 8'h00
`define FSRC_OFF_IRQ    8'h04
`define FSRC_OFF_MASK   8'h08
`define FSRC_OFF_CTRL   8'h0c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FSRC_SR_WIP     0
`define FSRC_SR_WEL     1
`define FSRC_SR_ERS     10
`define FSRC_SR_PRS     15
`define FSRC_EV_PAUSED  0
`define FSRC_EV_RESUMED 1
`define FSRC_EV_REFUSED 2
`define FSRC_EV_DONE    3
`define FSRC_CTRL_QLANE 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define FSRC_RST_MASK   4'h0
`define FSRC_RST_QLANE  1'b0

// ----------------------------------------------------------------
// protected region masks per paused operation
// ----------------------------------------------------------------
`define FSRC_MASK_PAGE  24'hffff00
`define FSRC_MASK_4K    24'hfff000
`define FSRC_MASK_32K   24'hff8000
`define FSRC_MASK_64K   24'hff0000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FSRC_CLK_MHZ    100
`define FSRC_PLAT_NS    20000
`define FSRC_ELAT_NS    30000
`define FSRC_PLAT_CYC   ((`FSRC_PLAT_NS * `FSRC_CLK_MHZ + 999) / 1000)
`define FSRC_ELAT_CYC   ((`FSRC_ELAT_NS * `FSRC_CLK_MHZ + 999) / 1000)
`define FSRC_RESUME_NS  300

`endif

// ---- src/fsrc_pkg.sv ----
// types shared by the pause controller and its bench
package fsrc_pkg;

   // ----------------------------------------------------------------
   // instruction codes seen on the serial link
   // ----------------------------------------------------------------
   typedef enum logic [7:0] {
      OP_WREN = 8'h06, OP_WRDI = 8'h04, OP_READ = 8'h03, OP_FAST = 8'h0b,
      OP_DOUT = 8'h3b, OP_QOUT = 8'h6b, OP_DIO = 8'hbb, OP_QIO = 8'heb,
      OP_QWORD = 8'he7, OP_WRAP = 8'h77, OP_MID = 8'h90, OP_MID2 = 8'h92,
      OP_MID4 = 8'h94, OP_JID = 8'h9f, OP_UID = 8'h4b, OP_RLS = 8'hab,
      OP_SECR = 8'h48, OP_PARAM = 8'h5a, OP_PP = 8'h02, OP_QPP = 8'h32,
      OP_RESUME = 8'h7a, OP_PAUSE = 8'h75, OP_RS1 = 8'h05, OP_RS2 = 8'h35,
      OP_RS3 = 8'h15, OP_RSTEN = 8'h66, OP_RST = 8'h99
   } fsrc_op_t;

   // kind of array operation the engine runs
   typedef enum logic [2:0] {K_PROG, K_ER4K, K_ER32K, K_ER64K, K_WRSR} fsrc_kind_t;

   // controller states
   typedef enum logic [2:0] {ST_IDLE, ST_BUSY, ST_PAUSING, ST_PAUSED, ST_NEST} fsrc_st_t;

   // report from the program/erase engine
   typedef struct packed {
      logic       start;
      fsrc_kind_t kind;
      logic [23:0] addr;
      logic       done;
   } fsrc_eng_t;

   // register port request
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } fsrc_bus_t;

   // instruction verdict
   typedef struct packed {
      logic       acc;
      logic       rej;
      logic       hit;
      logic [7:0] code;
   } fsrc_cmd_t;

   // whole state of the controller
   typedef struct packed {
      logic        sclk_s1;
      logic        sclk_s2;
      logic        sclk_d;
      logic        cs_s1;
      logic        cs_s2;
      logic        si_s1;
      logic        si_s2;
      logic [5:0]  bits;
      logic [31:0] shift;
      logic        chk;
      fsrc_st_t    st;
      fsrc_kind_t  kind;
      logic [23:0] base;
      logic [23:0] rmask;
      logic [11:0] cnt;
      logic        write_latch_armed;
      logic        prs;
      logic        ers;
      logic [3:0]  irq;
      logic [3:0]  imask;
      logic        qlane;
      logic [31:0] rdata;
      fsrc_cmd_t   cmd;
   } fsrc_state_t;

endpackage

// ---- src/fsrc_ctrl.sv ----
// suspend and resume controller of a serial nor flash
`timescale 1ns/1ns
`include "fsrc_defs.svh"

module fsrc_ctrl
(
   input  wire logic                 clk_in,
   input  wire logic                 rstn_in,
   input  wire logic                 sclk_in,
   input  wire logic                 cs_n_in,
   input  wire logic                 si_in,
   input  wire fsrc_pkg::fsrc_eng_t  eng_in,
   input  wire fsrc_pkg::fsrc_bus_t  bus_in,
   output logic      [31:0]          rdata_out,
   output logic                      irq_out,
   output logic                      eng_hold_out,
   output logic      [15:0]          status_out,
   output fsrc_pkg::fsrc_cmd_t       cmd_out
);
   import fsrc_pkg::*;

   // overview: the link pins are sampled by the system clock, so every
   // frame is rebuilt from synchronised copies of clock, select and data.
   // the opcode is judged on the eighth serial rise, and the address (if any)
   // on the thirty-second. the controller itself never runs the array; it
   // only tells the engine to hold, and tracks the flags the host polls.
   // trade-off: one shared state word keeps the whole block in one register,
   // at the cost of a wide next-state process. a serial half period must
   // span at least two system clocks or rises are merged and bits lost.

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   fsrc_state_t s_ff;
   fsrc_state_t nxt_s;
   logic [15:0] sr;
   logic        array_op_active;

   // protected span of the operation being paused
   function automatic logic [23:0] region_mask(input fsrc_kind_t k);
      logic [23:0] m;
      m = `FSRC_MASK_PAGE;
      unique case (k)
         K_ER4K:  m = `FSRC_MASK_4K;
         K_ER32K: m = `FSRC_MASK_32K;
         K_ER64K: m = `FSRC_MASK_64K;
         default: m = `FSRC_MASK_PAGE;
      endcase
      return m;
   endfunction

   // ----------------------------------------------------------------
   // status word
   // ----------------------------------------------------------------
   // busy stays up while paused-in-progress so the host keeps polling
   always_comb
   begin
      array_op_active = (s_ff.st == ST_BUSY) || (s_ff.st == ST_PAUSING)
         || (s_ff.st == ST_NEST);
      sr = 16'h0000;
      sr[`FSRC_SR_WIP] = array_op_active;
      sr[`FSRC_SR_WEL] = s_ff.write_latch_armed;
      sr[`FSRC_SR_ERS] = s_ff.ers;
      sr[`FSRC_SR_PRS] = s_ff.prs;
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      logic [7:0] op;
      logic [3:0] ev;
      logic       ok;
      logic       rise;
      logic       paused;
      op = {s_ff.shift[6:0], s_ff.si_s2};
      ev = 4'h0;
      ok = 1'b0;
      rise = s_ff.sclk_s2 & ~s_ff.sclk_d & ~s_ff.cs_s2;
      paused = (s_ff.st == ST_PAUSED) || (s_ff.st == ST_NEST);
      nxt_s = s_ff;

      // two-stage synchronisers for the link pins
      // only the second stage is read by logic; the first may be metastable.
      // the delayed copy of the clock gives a clean rise detector, and select
      // resets high so the first frame after reset starts from bit zero.
      // all three pins share the same delay, so data keeps its setup margin
      // against the synchronised clock edge.
      nxt_s.sclk_s1 = sclk_in;
      nxt_s.sclk_s2 = s_ff.sclk_s1;
      nxt_s.sclk_d = s_ff.sclk_s2;
      nxt_s.cs_s1 = cs_n_in;
      nxt_s.cs_s2 = s_ff.cs_s1;
      nxt_s.si_s1 = si_in;
      nxt_s.si_s2 = s_ff.si_s1;
      nxt_s.cmd.acc = 1'b0;
      nxt_s.cmd.rej = 1'b0;
      nxt_s.cmd.hit = 1'b0;

      // bit counting, restarted by every deselect
      if (s_ff.cs_s2)
      begin
         nxt_s.bits = 6'h00;
         nxt_s.chk = 1'b0;
      end
      else if (rise)
      begin
         nxt_s.shift = {s_ff.shift[30:0], s_ff.si_s2};
         if (s_ff.bits != 6'h3f)
         begin
            nxt_s.bits = s_ff.bits + 6'h01;
         end
      end

      // verdict on the eighth bit of the opcode
      // while the latency runs only status reads and reset may pass; once the
      // flag is up the wider list applies, page programs only in an erase
      // pause, and the quad form only when four lanes are enabled.
      // outside a pause every opcode is accepted; filtering there belongs to
      // the instruction decoder, not to this block.
      if (rise && (s_ff.bits == 6'h07))
      begin
         nxt_s.cmd.code = op;
         unique case (s_ff.st)
            ST_IDLE, ST_BUSY:
               ok = 1'b1;
            ST_PAUSING:
               ok = op inside {OP_RS1, OP_RS2, OP_RS3, OP_RSTEN, OP_RST};
            ST_PAUSED, ST_NEST:
               ok = (op inside {OP_RS1, OP_RS2, OP_RS3, OP_RSTEN, OP_RST})
                  || (op inside {OP_WREN, OP_WRDI, OP_READ, OP_FAST, OP_DOUT,
                     OP_QOUT, OP_DIO, OP_QIO, OP_QWORD, OP_WRAP, OP_MID,
                     OP_MID2, OP_MID4, OP_JID, OP_UID, OP_RLS, OP_SECR,
                     OP_PARAM, OP_RESUME})
                  || (s_ff.ers && ((op == OP_PP)
                     || ((op == OP_QPP) && s_ff.qlane)));
         endcase
         nxt_s.cmd.acc = ok;
         nxt_s.cmd.rej = ~ok;
         ev[`FSRC_EV_REFUSED] = ~ok;
         if (ok && (op == OP_WREN))
         begin
            nxt_s.write_latch_armed = 1'b1;
         end
         if (ok && (op == OP_WRDI))
         begin
            nxt_s.write_latch_armed = 1'b0;
         end
         // a pause only bites on a running program or erase
         if (ok && (op == OP_PAUSE) && (s_ff.st == ST_BUSY)
            && (s_ff.kind != K_WRSR))
         begin
            nxt_s.st = ST_PAUSING;
            nxt_s.cnt = (s_ff.kind == K_PROG) ? 12'(`FSRC_PLAT_CYC)
               : 12'(`FSRC_ELAT_CYC);
         end
         // resume only from a settled pause with the array idle
         if (ok && (op == OP_RESUME) && (s_ff.st == ST_PAUSED)
            && (s_ff.prs || s_ff.ers))
         begin
            nxt_s.st = ST_BUSY;
            nxt_s.prs = 1'b0;
            nxt_s.ers = 1'b0;
            ev[`FSRC_EV_RESUMED] = 1'b1;
         end
         nxt_s.chk = ok && paused && (op inside {OP_READ, OP_FAST, OP_DOUT,
            OP_QOUT, OP_DIO, OP_QIO, OP_QWORD, OP_PP, OP_QPP});
      end

      // address check after the third address byte
      // the shift register already holds opcode and 23 address bits, so the next
      // state copy is used to include the last address bit.
      // limitation: a frame cut short before the last byte is never checked,
      // which is harmless since such a frame cannot reach the array.
      if (rise && (s_ff.bits == 6'h1f) && s_ff.chk)
      begin
         nxt_s.chk = 1'b0;
         if ((nxt_s.shift[23:0] & s_ff.rmask) == s_ff.base)
         begin
            nxt_s.cmd.hit = 1'b1;
            ev[`FSRC_EV_REFUSED] = 1'b1;
         end
      end

      // pause latency, then latch cleared and flag raised together
      // the counter is loaded when the pause is accepted and counts to zero;
      // the host sees either busy with no flag, or the flag with the latch
      // already clear, never a mix of the two.
      if (s_ff.st == ST_PAUSING)
      begin
         if (s_ff.cnt == 12'h000)
         begin
            nxt_s.st = ST_PAUSED;
            nxt_s.write_latch_armed = 1'b0;
            nxt_s.prs = (s_ff.kind == K_PROG);
            nxt_s.ers = (s_ff.kind != K_PROG);
            ev[`FSRC_EV_PAUSED] = 1'b1;
         end
         else
         begin
            nxt_s.cnt = s_ff.cnt - 12'h001;
         end
      end

      // engine completion; a finish during the latency cancels the pause
      // a nested program ends back in the erase pause, so the flag stays set.
      // the latch always drops with a completion, as the host must arm it
      // again before the next program or erase.
      if (eng_in.done)
      begin
         if (s_ff.st == ST_NEST)
         begin
            nxt_s.st = ST_PAUSED;
         end
         else if ((s_ff.st == ST_BUSY) || (s_ff.st == ST_PAUSING))
         begin
            nxt_s.st = ST_IDLE;
            nxt_s.prs = 1'b0;
            nxt_s.ers = 1'b0;
         end
         nxt_s.write_latch_armed = 1'b0;
         ev[`FSRC_EV_DONE] = 1'b1;
      end

      // engine start; a program inside an erase pause nests
      // the protected region is latched at start, so a later nested program
      // cannot move the window of the paused erase.
      // a start during a program pause is ignored: nesting is erase-only.
      if (eng_in.start)
      begin
         if (s_ff.st == ST_IDLE)
         begin
            nxt_s.st = ST_BUSY;
            nxt_s.kind = eng_in.kind;
            nxt_s.rmask = region_mask(eng_in.kind);
            nxt_s.base = eng_in.addr & region_mask(eng_in.kind);
         end
         else if ((s_ff.st == ST_PAUSED) && s_ff.ers)
         begin
            nxt_s.st = ST_NEST;
         end
      end

      // register port: read data valid for one cycle only
      // the port never stalls: every strobe is answered on the next edge.
      // unmapped reads return zero and unmapped writes are dropped, so a
      // stray access cannot disturb the pause state.
      nxt_s.rdata = 32'h0000_0000;
      if (bus_in.rd)
      begin
         unique case (bus_in.addr)
            `FSRC_OFF_STATUS: nxt_s.rdata = {16'h0000, sr};
            `FSRC_OFF_IRQ:    nxt_s.rdata = {28'h0000000, s_ff.irq};
            `FSRC_OFF_MASK:   nxt_s.rdata = {28'h0000000, s_ff.imask};
            `FSRC_OFF_CTRL:   nxt_s.rdata = {31'h00000000, s_ff.qlane};
            default:          nxt_s.rdata = 32'h0000_0000;
         endcase
      end
      if (bus_in.wr && (bus_in.addr == `FSRC_OFF_MASK))
      begin
         nxt_s.imask = bus_in.wdata[3:0];
      end
      if (bus_in.wr && (bus_in.addr == `FSRC_OFF_CTRL))
      begin
         nxt_s.qlane = bus_in.wdata[`FSRC_CTRL_QLANE];
      end

      // sticky events: a new event beats the clear-on-read
      nxt_s.irq = ((bus_in.rd && (bus_in.addr == `FSRC_OFF_IRQ))
         ? 4'h0 : s_ff.irq) | ev;
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   // select lines reset high so a stale frame cannot start counting
   // reset is synchronous; every field of the state word takes a constant,
   // so a single reset edge also clears the link synchronisers.
   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         s_ff <= '0;
         s_ff.cs_s1 <= 1'b1;
         s_ff.cs_s2 <= 1'b1;
         s_ff.imask <= `FSRC_RST_MASK;
         s_ff.qlane <= `FSRC_RST_QLANE;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // every output comes straight from the state register or the status word,
   // which is itself built only from registered fields; nothing on the link
   // pins reaches an output without passing the synchronisers first.
   // the hold output stays low in a nested program so the engine can run it
   // while the paused erase waits.
   assign rdata_out = s_ff.rdata;
   assign irq_out = |(s_ff.irq & s_ff.imask);
   assign eng_hold_out = (s_ff.st == ST_PAUSING) || (s_ff.st == ST_PAUSED); // engine halts
   assign status_out = sr;
   assign cmd_out = s_ff.cmd;

endmodule // fsrc_ctrl

// ---- test/fsrc_ctrl_props.sv ----
// concurrent checks on the ports of the pause controller
`timescale 1ns/1ns
`include "fsrc_defs.svh"
module fsrc_ctrl_props
(
   input  wire logic                 clk_in,
   input  wire logic                 rstn_in,
   input  wire logic                 sclk_in,
   input  wire logic                 cs_n_in,
   input  wire logic                 si_in,
   input  wire fsrc_pkg::fsrc_eng_t  eng_in,
   input  wire fsrc_pkg::fsrc_bus_t  bus_in,
   input  wire logic      [31:0]     rdata_out,
   input  wire logic                 irq_out,
   input  wire logic                 eng_hold_out,
   input  wire logic      [15:0]     status_out,
   input  wire fsrc_pkg::fsrc_cmd_t  cmd_out
);
   import fsrc_pkg::*;
   localparam int PL = `FSRC_PLAT_CYC;
   localparam int EL = `FSRC_ELAT_CYC;
   logic [11:0] hold_ff;
   logic        flag;

   // ----------------------------------------------------------------
   // helper: cycles the engine has been held, small slack for the pipeline
   // ----------------------------------------------------------------
   assign flag = status_out[15] | status_out[10];
   always_ff @(posedge clk_in)
   begin
      hold_ff <= (!rstn_in || !eng_hold_out) ? 12'h000 : hold_ff + 12'h001;
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   latency_ok_a: assert property ($rose(flag) |-> (status_out[15] ?
      (hold_ff >= PL - 3 && hold_ff <= PL + 3) : (hold_ff >= EL - 3 && hold_ff <= EL + 3)))
      else $error("pause latency off");
   flag_entry_a: assert property ($rose(flag) |-> status_out[1:0] == 2'b00)
      else $error("latch or busy set at pause entry");
   pause_cause_a: assert property ($rose(flag) |-> $past(eng_hold_out))
      else $error("flag without a held operation");
   flags_excl_a: assert property (!(status_out[15] && status_out[10]))
      else $error("both pause flags set");
   resume_busy_a: assert property ($fell(flag) |-> ##[0:30] status_out[0])
      else $error("busy late after resume");
   prog_refuse_a: assert property (cmd_out.acc && status_out[15] |->
      !(cmd_out.code inside {8'h02, 8'h32})) else $error("program taken in program pause");
   pause_refuse_a: assert property (cmd_out.acc && flag |->
      !(cmd_out.code inside {8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7, 8'h01}))
      else $error("erase or status write taken in pause");
   verdict_excl_a: assert property (!(cmd_out.acc && cmd_out.rej))
      else $error("accept and refuse together");
   rdata_idle_a: assert property (!$past(bus_in.rd) |-> rdata_out == 32'h0)
      else $error("read data outside read slot");

   cover property ($rose(status_out[15]));
   cover property ($rose(status_out[10]));
   cover property (cmd_out.hit);
endmodule // fsrc_ctrl_props

bind fsrc_ctrl fsrc_ctrl_props props_u
(
   .clk_in(clk_in), .rstn_in(rstn_in), .sclk_in(sclk_in), .cs_n_in(cs_n_in),
   .si_in(si_in), .eng_in(eng_in), .bus_in(bus_in), .rdata_out(rdata_out),
   .irq_out(irq_out), .eng_hold_out(eng_hold_out), .status_out(status_out),
   .cmd_out(cmd_out)
);

// ---- test/fsrc_host.sv ----
// serial host model: opcode and address frames, mode 0, msb first
`timescale 1ns/1ns
module fsrc_host
(
   output logic sclk_out,
   output logic cs_n_out,
   output logic si_out
);
   // ----------------------------------------------------------------
   // idle: clock still low, select high
   // ----------------------------------------------------------------
   initial
   begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      si_out   = 1'b0;
   end

   // odd start offset keeps the link out of phase with the system clock
   task automatic send(input logic [31:0] word, input int nbits);
      #13 cs_n_out = 1'b0;
      for (int i = 31; i > 31 - nbits; i--)
      begin
         si_out = word[i];
         #40 sclk_out = 1'b1;
         #40 sclk_out = 1'b0;
      end
      #40 cs_n_out = 1'b1;
      si_out = ~si_out; // released line flips so no stale bit is trusted
   endtask
endmodule // fsrc_host

// ---- test/testbench.sv ----
// self-checking bench of the pause controller
`timescale 1ns/1ns
`include "fsrc_defs.svh"
module testbench;
   import fsrc_pkg::*;
   logic        clk_in, rstn_in, sclk, cs_n, si, irq, hold, qlane;
   fsrc_eng_t   eng;
   fsrc_bus_t   bus;
   fsrc_cmd_t   cmd;
   fsrc_kind_t  k;
   logic [31:0] rdata, d;
   logic [15:0] status;
   logic [23:0] a;
   logic [2:0]  res;
   int          n_tests = 0, n_mismatch = 0, n_acc = 0, n_rej = 0, n_hit = 0;
   fsrc_op_t    okops[17] = '{OP_WREN, OP_WRDI, OP_FAST, OP_DOUT, OP_QOUT, OP_DIO, OP_QIO,
      OP_QWORD, OP_WRAP, OP_MID, OP_MID2, OP_MID4, OP_JID, OP_UID, OP_RLS, OP_SECR, OP_PARAM};
   fsrc_op_t    fastops[4] = '{OP_RS1, OP_RS2, OP_RS3, OP_RSTEN};

   fsrc_host host_u (.sclk_out(sclk), .cs_n_out(cs_n), .si_out(si));
   fsrc_ctrl dut_u
   (
      .clk_in(clk_in), .rstn_in(rstn_in), .sclk_in(sclk), .cs_n_in(cs_n), .si_in(si),
      .eng_in(eng), .bus_in(bus), .rdata_out(rdata), .irq_out(irq),
      .eng_hold_out(hold), .status_out(status), .cmd_out(cmd)
   );

   initial
   begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   // verdict pulses are counted so a frame can tell what it caused
   always @(posedge clk_in)
   begin
      n_acc <= n_acc + int'(cmd.acc);
      n_rej <= n_rej + int'(cmd.rej);
      n_hit <= n_hit + int'(cmd.hit);
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
      @(posedge clk_in);
      bus <= '{addr: ad, wdata: wd, wr: 1'b1, rd: 1'b0};
      @(posedge clk_in);
      bus.wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] ad, output logic [31:0] rv);
      @(posedge clk_in);
      bus <= '{addr: ad, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk_in);
      bus.rd <= 1'b0;
      #1 rv = rdata;
   endtask

   task automatic pulse(input logic st, input fsrc_kind_t kd, input logic [23:0] ad);
      @(posedge clk_in);
      eng <= '{start: st, kind: kd, addr: ad, done: !st};
      @(posedge clk_in);
      eng <= '{start: 1'b0, kind: kd, addr: ad, done: 1'b0};
   endtask

   // result is {hit, refused, accepted}; pulses land about 3 clocks after the bit
   task automatic frame(input logic [7:0] op, input logic [23:0] ad, output logic [2:0] r);
      int a0, r0, h0;
      a0 = n_acc;
      r0 = n_rej;
      h0 = n_hit;
      host_u.send({op, ad}, 32);
      repeat (10) @(posedge clk_in);
      r = {n_hit > h0, n_rej > r0, n_acc > a0};
   endtask

   task automatic wait_flag();
      int i;
      for (i = 0; i < 4000 && !(status[15] | status[10]); i++)
         @(posedge clk_in);
      if (i == 4000)
      begin
         n_mismatch++;
         stop_test();
      end
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      rstn_in = 1'b0;
      eng = '0;
      bus = '0;
      void'($urandom(73879));
      repeat (12) @(posedge clk_in);
      rstn_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      qlane = 1'($urandom);
      wr(`FSRC_OFF_MASK, 32'h1);
      wr(`FSRC_OFF_CTRL, {31'h0, qlane});
      rd(`FSRC_OFF_MASK, d);
      check(d, 32'h1);
      rd(`FSRC_OFF_CTRL, d);
      check(d, {31'h0, qlane});
      rd(8'h10, d);
      check(d, 32'h0);
      frame(OP_PAUSE, 24'h0, res);
      check(32'({hold, status}), 32'h0);
      $display("registers and idle pause done");
      pulse(1'b1, K_WRSR, 24'h0);
      frame(OP_PAUSE, 24'h0, res);
      repeat (3100) @(posedge clk_in);
      check(32'({hold, status}), 32'h1);
      pulse(1'b0, K_WRSR, 24'h0);
      $display("status write pause done");
      for (int j = 0; j < 4; j++)
      begin
         k = fsrc_kind_t'(j);
         a = 24'($urandom);
         frame(OP_WREN, a, res);
         pulse(1'b1, k, a);
         repeat (100) @(posedge clk_in);
         frame(OP_PAUSE, a, res);
         check(32'(res), 32'h1);
         foreach (fastops[m])
         begin
            frame(fastops[m], a, res);
            check(32'(res), 32'h1);
         end
         frame(OP_RESUME, a, res);
         check(32'(res), 32'h2);
         wait_flag();
         check(32'({hold, status}), (k == K_PROG) ? 32'h18000 : 32'h10400);
         check(32'(irq), 32'h1);
         rd(`FSRC_OFF_IRQ, d);
         @(posedge clk_in);
         check(32'({irq, d[0]}), 32'h1);
         frame(OP_READ, a ^ 24'h000001, res);
         check(32'(res[2]), 32'h1);
         frame(OP_READ, a ^ 24'h010000, res);
         check(32'(res), 32'h1);
         frame(OP_PP, a ^ 24'h010000, res);
         check(32'(res), (k == K_PROG) ? 32'h2 : 32'h1);
         frame(OP_QPP, a ^ 24'h010000, res);
         check(32'(res), (k != K_PROG && qlane) ? 32'h1 : 32'h2);
         frame(8'h20, a, res);
         check(32'(res), 32'h2);
         foreach (okops[m])
         begin
            frame(okops[m], a ^ 24'h010000, res);
            check(32'(res), 32'h1);
         end
         frame(OP_RESUME, a, res);
         check(32'(res), 32'h1);
         check(32'({hold, status}), 32'h1);
         pulse(1'b0, k, a);
         repeat (2) @(posedge clk_in);
         check(32'({hold, status}), 32'h0);
         $display("pause and resume of kind %0d done", j);
      end
      stop_test();
   end
endmodule // testbench
